// ### rtl/wws_pkg.sv
// Shared constants and types of the watchdog and reset supervisor
package wws_pkg;

  // ----------------------------------------
  // Clock and time base
  // ----------------------------------------
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TICK_HZ     = 1_000_000;
  localparam int unsigned TICK_CYC    = CLK_HZ / TICK_HZ;
  localparam int unsigned TMR_W       = 18;
  localparam int unsigned LONG_WIN_MS = 65;
  localparam int unsigned REG_OFF_MS  = 200;
  localparam int unsigned REL_DLY_MS  = 2;
  localparam int unsigned SHORT_MS    = 4;
  localparam int unsigned CLOSED_MS   = 10;
  localparam int unsigned OPEN_MS     = 10;
  localparam int unsigned US_PER_MS   = 1000;

  // ----------------------------------------
  // Failure counts
  // ----------------------------------------
  localparam logic [3:0] FAIL_OFF  = 4'h8;
  localparam logic [3:0] FAIL_STBY = 4'hf;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [3:0] ADDR_SERVICE = 4'h0;
  localparam logic [3:0] ADDR_CTRL    = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;
  localparam logic [3:0] ADDR_STATE   = 4'hc;
  localparam int unsigned SVC_BIT   = 0;
  localparam int unsigned CTL_HOLD  = 0;
  localparam int unsigned CTL_LOAD_CURRENT_COMPARE_BIT  = 1;
  localparam int unsigned CTL_VTH   = 2;
  localparam logic [2:0] CTRL_RST   = 3'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RESET  = 3'h0,
    ST_LONG   = 3'h1,
    ST_CLOSED = 3'h3,
    ST_OPEN   = 3'h2,
    ST_OFF    = 3'h6,
    ST_STBY   = 3'h7
  } wws_state_t;

  // Index 0 charge-pump supply, 1 regulator supply, 2 motor supply sense
  typedef struct packed {
    logic [2:0] ov_warn;
    logic [2:0] ov;
    logic [2:0] uv;
  } wws_supply_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } wws_bus_t;

  localparam int unsigned SUP_CP  = 0;
  localparam int unsigned SUP_MSS = 2;

endpackage

// ### rtl/wws_top.sv
// Window watchdog, reset generator and supply fault supervisor
`timescale 1ns/1ps
// Contract
// - After reset release the watchdog starts with a 65 ms long open window.
// - A correct toggled write restarts window timing at once.
// - Eight failures in a row turn the regulator off for 200 ms.
// - Seven more failures in a row turn it off until a wake event: battery standby.
// - Each failure pulses the reset output and disables the gate drivers.
// - Programming mode disables the watchdog and raises no failure.
// - In regulator standby, supervise only with compare bit zero and load high.
// - Hold-off bit set in programming mode keeps watchdog off until power-on reset.
// - Failure, undervoltage or standby wake restart the long window.
// - Rewriting the same service value inside the window is no failure.
// - Reset output releases 2 ms after regulator output passes the threshold.
// - Undervoltage pulses reset, latches flag; clear only once voltage is back.
// - Regulator output below failure level 4 ms: short flag, battery standby.
// - Short flag clears only after short gone and a wake left standby.
// - Overvoltage warning flags latch per supply; clear once condition gone.
// - Overvoltage flags latch; pump and motor sense overvoltage disable gates.
// - Undervoltage flags latch per supply, report only, clear once gone.
// - Flash entry pin high puts the device in programming mode.
module wws_top
  import wws_pkg::*;
#(
  parameter logic [TMR_W-1:0] LONG_TICKS   = TMR_W'(LONG_WIN_MS * US_PER_MS),
  parameter logic [TMR_W-1:0] OFF_TICKS    = TMR_W'(REG_OFF_MS * US_PER_MS),
  parameter logic [TMR_W-1:0] REL_TICKS    = TMR_W'(REL_DLY_MS * US_PER_MS),
  parameter logic [TMR_W-1:0] SHORT_TICKS  = TMR_W'(SHORT_MS * US_PER_MS),
  parameter logic [TMR_W-1:0] CLOSED_TICKS = TMR_W'(CLOSED_MS * US_PER_MS),
  parameter logic [TMR_W-1:0] OPEN_TICKS   = TMR_W'(OPEN_MS * US_PER_MS)
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // Register port
  input  wire wws_pkg::wws_bus_t    bus,
  output logic [31:0]               rdata,
  // Comparators and mode inputs
  input  wire logic                 vdd_above_rt1,
  input  wire logic                 vdd_above_rt2,
  input  wire logic                 vdd_below_fail,
  input  wire wws_pkg::wws_supply_t supply,
  input  wire logic                 flash_entry_pin,
  input  wire logic                 vdd_standby_mode,
  input  wire logic                 load_current_high,
  input  wire logic                 wake_event,
  // Outputs
  output logic                      reset_out_n,
  output logic                      regulator_en,
  output logic                      gate_disable,
  output logic                      vbat_standby
);
  import wws_pkg::*;

  // ----------------------------------------
  // Tick divider
  // ----------------------------------------
  logic [5:0] div_q, div_d;
  logic       tick;
  always_comb begin
    tick  = (div_q == 6'(TICK_CYC - 1));
    div_d = tick ? 6'h00 : div_q + 6'h01;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) div_q <= 6'h00;
    else div_q <= div_d;
  end

  // ----------------------------------------
  // Control register and hold-off lock
  // ----------------------------------------
  logic [2:0] ctrl_q, ctrl_d;
  logic       lock_q, lock_d;
  logic       flash_mode, ctrl_wr, svc_wr, svc_val, st_rd, wd_run;
  always_comb begin
    flash_mode = flash_entry_pin;
    ctrl_wr    = bus.wr && (bus.addr == ADDR_CTRL);
    svc_wr     = bus.wr && (bus.addr == ADDR_SERVICE);
    svc_val    = bus.wdata[SVC_BIT];
    st_rd      = bus.rd && (bus.addr == ADDR_STATUS);
    ctrl_d     = ctrl_wr ? bus.wdata[2:0] : ctrl_q;
    lock_d     = lock_q | (ctrl_wr && bus.wdata[CTL_HOLD] && flash_mode);
    wd_run     = !flash_mode && !lock_q &&
                 (!vdd_standby_mode || (!ctrl_q[CTL_LOAD_CURRENT_COMPARE_BIT] && load_current_high));
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RST;
      lock_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      lock_q <= lock_d;
    end
  end

  // ----------------------------------------
  // Watchdog and reset sequencer
  // ----------------------------------------
  wws_state_t       st_q, st_d;
  logic [TMR_W-1:0] tmr_q, tmr_d, sh_q, sh_d;
  logic [3:0]       cnt_q, cnt_d;
  logic             last_q, last_d, fs_q, fs_d;
  logic             fail, acc, vdd_ok, reg_on, tmr_clr;
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    last_d  = last_q;
    fs_d    = fs_q;
    fail    = 1'b0;
    acc     = 1'b0;
    tmr_clr = 1'b0;
    reg_on  = (st_q != ST_OFF) && (st_q != ST_STBY);
    vdd_ok  = ctrl_q[CTL_VTH] ? vdd_above_rt2 : vdd_above_rt1;
    case (st_q)
      ST_RESET: begin
        tmr_clr = !vdd_ok;
        if (tmr_q >= REL_TICKS) st_d = ST_LONG;
      end
      ST_LONG: begin
        last_d = 1'b0;
        if (!wd_run) tmr_clr = 1'b1;
        else if (svc_wr && svc_val) begin
          acc    = 1'b1;
          last_d = 1'b1;
          st_d   = ST_CLOSED;
        end else if (tmr_q >= LONG_TICKS) fail = 1'b1;
      end
      ST_CLOSED: begin
        if (!wd_run) st_d = ST_LONG;
        else if (svc_wr && svc_val != last_q) fail = 1'b1;
        else if (tmr_q >= CLOSED_TICKS) st_d = ST_OPEN;
      end
      ST_OPEN: begin
        if (!wd_run) st_d = ST_LONG;
        else if (svc_wr && svc_val != last_q) begin
          acc    = 1'b1;
          last_d = svc_val;
          st_d   = ST_CLOSED;
        end else if (tmr_q >= OPEN_TICKS) fail = 1'b1;
      end
      ST_OFF: begin
        if (tmr_q >= OFF_TICKS) st_d = ST_RESET;
      end
      ST_STBY: begin
        cnt_d = 4'h0;
        if (wake_event) st_d = ST_RESET;
      end
      default: st_d = ST_RESET;
    endcase
    if (fail) begin
      cnt_d = cnt_q + 4'h1;
      fs_d  = 1'b1;
      if (cnt_d == FAIL_OFF) st_d = ST_OFF;
      else if (cnt_d == FAIL_STBY) st_d = ST_STBY;
      else st_d = ST_RESET;
    end
    if (acc) begin
      cnt_d = 4'h0;
      fs_d  = 1'b0;
    end
    if (reg_on && !vdd_ok && st_q != ST_RESET && st_d != ST_OFF && st_d != ST_STBY)
      st_d = ST_RESET;
    sh_d = (reg_on && vdd_below_fail) ? (tick ? sh_q + TMR_W'(1) : sh_q) : '0;
    if (reg_on && sh_q >= SHORT_TICKS) st_d = ST_STBY;
    if (st_d != st_q || acc || tmr_clr) tmr_d = '0;
    else if (tick && tmr_q != '1) tmr_d = tmr_q + TMR_W'(1);
    else tmr_d = tmr_q;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= ST_RESET;
      tmr_q  <= '0;
      sh_q   <= '0;
      cnt_q  <= 4'h0;
      last_q <= 1'b0;
      fs_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      last_q <= last_d;
      fs_q   <= fs_d;
    end
  end

  // ----------------------------------------
  // Latched fault flags
  // ----------------------------------------
  logic [8:0] sup_q, sup_d, sup_in;
  logic       uvf_q, uvf_d, shf_q, shf_d, wk_q, wk_d;
  always_comb begin
    sup_in = {supply.uv, supply.ov, supply.ov_warn};
    sup_d  = sup_in | (sup_q & ~({9{st_rd}} & ~sup_in));
    uvf_d  = (reg_on && !vdd_ok && st_q != ST_RESET) | (uvf_q & ~(st_rd & vdd_ok));
    wk_d   = (st_q == ST_STBY && wake_event) | (wk_q & ~(reg_on && sh_q >= SHORT_TICKS));
    shf_d  = (reg_on && sh_q >= SHORT_TICKS) |
             (shf_q & ~(st_rd && !vdd_below_fail && wk_q && st_q != ST_STBY));
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sup_q <= 9'h000;
      uvf_q <= 1'b0;
      shf_q <= 1'b0;
      wk_q  <= 1'b0;
    end else begin
      sup_q <= sup_d;
      uvf_q <= uvf_d;
      shf_q <= shf_d;
      wk_q  <= wk_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic out_rst_n_q, out_rst_n_d, out_reg_q, out_reg_d;
  logic out_gd_q, out_gd_d, out_sb_q, out_sb_d;
  always_comb begin
    out_rst_n_d = (st_d != ST_RESET) && (st_d != ST_OFF) && (st_d != ST_STBY);
    out_reg_d   = (st_d != ST_OFF) && (st_d != ST_STBY);
    out_sb_d    = (st_d == ST_STBY);
    out_gd_d    = fs_d || !out_rst_n_d ||
                  sup_d[3 + SUP_CP] || sup_d[3 + SUP_MSS];
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_rst_n_q <= 1'b0;
      out_reg_q   <= 1'b1;
      out_gd_q    <= 1'b1;
      out_sb_q    <= 1'b0;
    end else begin
      out_rst_n_q <= out_rst_n_d;
      out_reg_q   <= out_reg_d;
      out_gd_q    <= out_gd_d;
      out_sb_q    <= out_sb_d;
    end
  end
  assign reset_out_n  = out_rst_n_q;
  assign regulator_en = out_reg_q;
  assign gate_disable = out_gd_q;
  assign vbat_standby = out_sb_q;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rd_q, rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL:   rd_d = {29'h0, ctrl_q};
        ADDR_STATUS: rd_d = {21'h0, sup_q, shf_q, uvf_q};
        ADDR_STATE:  rd_d = {20'h0, flash_mode, fs_q, lock_q, last_q, cnt_q, 1'b0, st_q};
        default:     rd_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rd_q <= 32'h0000_0000;
    else rd_q <= rd_d;
  end
  assign rdata = rd_q;

endmodule

// ### sim/tb.sv
// Self-checking bench of the watchdog and reset supervisor
`timescale 1ns/1ps
module tb;
  import wws_pkg::*;
  logic clk, arst_n, vok, vfail, flash, start, busy;
  logic vok2, wake, sbm, load;
  logic reset_out_n, regulator_en, gate_disable, vbat_standby;
  logic [31:0] rdata;
  wws_bus_t tb_bus, mcu_bus, bus;
  wws_supply_t sup;
  int err_total, total_checks;
  assign bus = mcu_bus.wr ? mcu_bus : tb_bus;
  wws_top #(.LONG_TICKS(18'h14), .OFF_TICKS(18'h28), .REL_TICKS(18'h5), .SHORT_TICKS(18'ha),
    .CLOSED_TICKS(18'ha), .OPEN_TICKS(18'ha)) uut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
    .vdd_above_rt1(vok), .vdd_above_rt2(vok2), .vdd_below_fail(vfail), .supply(sup),
    .flash_entry_pin(flash), .vdd_standby_mode(sbm), .load_current_high(load), .wake_event(wake),
    .reset_out_n(reset_out_n), .regulator_en(regulator_en), .gate_disable(gate_disable),
    .vbat_standby(vbat_standby));
  wws_mcu u_mcu (.clk(clk), .arst_n(arst_n), .start(start), .n(4'h6), .bus(mcu_bus), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) tb_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) tb_bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk) tb_bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) tb_bus.rd <= 1'b0;
    #1 cmp(rdata & m, exp);
  endtask
  task automatic till(input int s, input logic v, input int lim);
    int i;
    logic x;
    for (i = 0; i < lim; i++) begin
      @(posedge clk);
      #1 x = (s == 0) ? reset_out_n : (s == 1) ? regulator_en : (s == 2) ? vbat_standby : busy;
      if (x === v) break;
    end
    cmp({31'h0, x}, {31'h0, v});
  endtask
  task automatic por();
    @(posedge clk) arst_n <= 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    till(0, 1'b1, 400);
  endtask
  initial begin
    #1500000 err_total++;
    summarize();
  end
  initial begin
    tb_bus = '0;
    sup = '0;
    {vok, vfail, flash, start, arst_n} = 5'h10;
    {vok2, wake, sbm, load} = 4'h8;
    err_total = 0;
    total_checks = 0;
    por();
    rd(ADDR_STATE, 32'h1, 32'h7);
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    till(3, 1'b0, 4000);
    rd(ADDR_STATE, 32'h3, 32'h1f7);
    cmp({31'h0, gate_disable}, 32'h0);
    wr(ADDR_SERVICE, 32'h0);
    repeat (500) @(posedge clk);
    wr(ADDR_SERVICE, 32'h1);
    rd(ADDR_STATE, 32'h103, 32'h1f7);
    @(posedge clk) sup <= 9'h1ff;
    repeat (3) @(posedge clk);
    #1 cmp({31'h0, gate_disable}, 32'h1);
    @(posedge clk) sup <= 9'h1c0;
    rd(ADDR_STATUS, 32'h7fc, 32'h7ff);
    rd(ADDR_STATUS, 32'h1c, 32'h7ff);
    @(posedge clk) sup <= 9'h0;
    wr(ADDR_SERVICE, 32'h0);
    repeat (2) @(posedge clk);
    #1 cmp({30'h0, reset_out_n, gate_disable}, 32'h1);
    rd(ADDR_STATE, 32'h10, 32'hf0);
    till(0, 1'b1, 400);
    rd(ADDR_STATE, 32'h1, 32'h7);
    @(posedge clk) {vok, vok2} <= 2'b00;
    rd(ADDR_STATUS, 32'h1, 32'h1);
    @(posedge clk) {vok, vok2} <= 2'b11;
    till(0, 1'b1, 400);
    rd(ADDR_STATUS, 32'h1, 32'h1);
    rd(ADDR_STATUS, 32'h0, 32'h1);
    @(posedge clk) flash <= 1'b1;
    repeat (1200) @(posedge clk);
    #1 cmp({31'h0, reset_out_n}, 32'h1);
    rd(ADDR_STATE, 32'h811, 32'h8f7);
    wr(ADDR_CTRL, 32'h1);
    @(posedge clk) flash <= 1'b0;
    repeat (1000) @(posedge clk);
    rd(ADDR_STATE, 32'h211, 32'haf7);
    @(posedge clk) vfail <= 1'b1;
    till(2, 1'b1, 600);
    rd(ADDR_STATUS, 32'h2, 32'h2);
    @(posedge clk) vfail <= 1'b0;
    rd(ADDR_STATUS, 32'h2, 32'h2);
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    till(0, 1'b1, 400);
    rd(ADDR_STATE, 32'h1, 32'hf7);
    rd(ADDR_STATUS, 32'h2, 32'h2);
    rd(ADDR_STATUS, 32'h0, 32'h2);
    por();
    till(1, 1'b0, 10000);
    rd(ADDR_STATE, 32'h86, 32'hf7);
    till(1, 1'b1, 2000);
    till(2, 1'b1, 10000);
    cmp({31'h0, regulator_en}, 32'h0);
    rd(ADDR_STATE, 32'h7, 32'h7);
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    till(0, 1'b1, 400);
    rd(ADDR_STATE, 32'h1, 32'hf7);
    @(posedge clk) sbm <= 1'b1;
    repeat (1000) @(posedge clk);
    rd(ADDR_STATE, 32'h1, 32'hf7);
    wr(ADDR_CTRL, 32'h2);
    @(posedge clk) load <= 1'b1;
    repeat (1000) @(posedge clk);
    rd(ADDR_STATE, 32'h1, 32'hf7);
    wr(ADDR_CTRL, 32'h0);
    till(0, 1'b0, 1000);
    rd(ADDR_STATE, 32'h10, 32'hf7);
    till(0, 1'b1, 400);
    wr(ADDR_SERVICE, 32'h1);
    rd(ADDR_STATE, 32'h103, 32'h1f7);
    wr(ADDR_CTRL, 32'h4);
    rd(ADDR_CTRL, 32'h4, 32'h7);
    @(posedge clk) vok <= 1'b0;
    repeat (3) @(posedge clk);
    #1 cmp({31'h0, reset_out_n}, 32'h1);
    @(posedge clk) vok2 <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp({31'h0, reset_out_n}, 32'h0);
    rd(ADDR_STATUS, 32'h1, 32'h1);
    summarize();
  end
endmodule

// ### sim/wws_mcu.sv
// Microcontroller model that services the watchdog
`timescale 1ns/1ps
module wws_mcu
  import wws_pkg::*;
#(
  parameter int GAP = 500
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic [3:0] n,
  output wws_pkg::wws_bus_t bus,
  output logic            busy
);
  logic [3:0] left;
  int         tmr;
  logic       val;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus  <= '0;
      busy <= 1'b0;
      left <= 4'h0;
      tmr  <= 0;
      val  <= 1'b1;
    end else begin
      bus.wr <= 1'b0;
      bus.wdata <= ~bus.wdata;
      if (start) begin
        busy <= 1'b1;
        left <= n;
        tmr  <= 0;
        val  <= 1'b1;
      end else if (busy) begin
        if (tmr != 0) begin
          tmr <= tmr - 1;
        end else begin
          bus.addr  <= ADDR_SERVICE;
          bus.wdata <= {31'h0, val};
          bus.wr    <= 1'b1;
          val  <= !val;
          left <= left - 4'h1;
          busy <= (left != 4'h1);
          tmr  <= GAP;
        end
      end
    end
  end
endmodule

// ### sim/wws_top_monitor.sv
// Concurrent checks on the ports of the watchdog and reset supervisor
`timescale 1ns/1ps
module wws_top_monitor
  import wws_pkg::*;
#(
  parameter logic [TMR_W-1:0] LONG_TICKS   = 18'h14,
  parameter logic [TMR_W-1:0] OFF_TICKS    = 18'h28,
  parameter logic [TMR_W-1:0] REL_TICKS    = 18'h5,
  parameter logic [TMR_W-1:0] CLOSED_TICKS = 18'ha,
  parameter logic [TMR_W-1:0] OPEN_TICKS   = 18'ha
) (
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire wws_pkg::wws_bus_t    bus,
  input wire logic [31:0]          rdata,
  input wire logic                 vdd_above_rt1,
  input wire logic                 vdd_above_rt2,
  input wire wws_pkg::wws_supply_t supply,
  input wire logic                 flash_entry_pin,
  input wire logic                 reset_out_n,
  input wire logic                 regulator_en,
  input wire logic                 gate_disable,
  input wire logic                 vbat_standby
);
  localparam int REL_MIN = (int'(REL_TICKS) - 1) * TICK_CYC;
  localparam int OFF_MIN = (int'(OFF_TICKS) - 1) * TICK_CYC;
  localparam int WIN_MAX = (int'(LONG_TICKS) + int'(CLOSED_TICKS) + int'(OPEN_TICKS) + 2) * TICK_CYC;
  int ok_cnt;
  int off_cnt;
  int quiet;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Elapsed-time counters
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ok_cnt  <= 0;
      off_cnt <= 0;
      quiet   <= 0;
    end else begin
      ok_cnt  <= (vdd_above_rt1 && vdd_above_rt2) ? ok_cnt + 1 : 0;
      off_cnt <= regulator_en ? 0 : off_cnt + 1;
      quiet   <= (!reset_out_n || bus.wr || flash_entry_pin) ? 0 : quiet + 1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_gate; !reset_out_n |-> gate_disable; endproperty
  property p_rel; $rose(reset_out_n) |-> ok_cnt >= REL_MIN; endproperty
  property p_off; $rose(regulator_en) && !$past(vbat_standby) |-> off_cnt >= OFF_MIN; endproperty
  property p_stby; vbat_standby && $past(vbat_standby) |-> !regulator_en; endproperty
  property p_ov; supply.ov[SUP_CP] || supply.ov[SUP_MSS] |-> ##[1:2] gate_disable; endproperty
  property p_flash; flash_entry_pin && $past(flash_entry_pin) && vdd_above_rt1 |-> !$fell(reset_out_n); endproperty
  property p_uv; !vdd_above_rt1 && !vdd_above_rt2 |-> ##[1:3] !reset_out_n; endproperty
  property p_win; quiet <= WIN_MAX; endproperty
  property p_rd; !$past(bus.rd) |-> rdata == 32'h0; endproperty
  a_gate: assert property (p_gate) else $error("gates on while reset low");
  a_rel: assert property (p_rel) else $error("reset released early");
  a_off: assert property (p_off) else $error("regulator back on early");
  a_stby: assert property (p_stby) else $error("regulator on in standby");
  a_ov: assert property (p_ov) else $error("gates on during overvoltage");
  a_flash: assert property (p_flash) else $error("reset pulse in flash mode");
  a_uv: assert property (p_uv) else $error("no reset on undervoltage");
  a_win: assert property (p_win) else $error("window expiry missed");
  a_rd: assert property (p_rd) else $error("read data outside read slot");
  c_rel: cover property ($rose(reset_out_n));
  c_off: cover property ($fell(regulator_en));
  c_stby: cover property ($rose(vbat_standby));
endmodule

bind wws_top wws_top_monitor #(.LONG_TICKS(LONG_TICKS), .OFF_TICKS(OFF_TICKS), .REL_TICKS(REL_TICKS),
  .CLOSED_TICKS(CLOSED_TICKS), .OPEN_TICKS(OPEN_TICKS)) u_mon (.clk(clk), .arst_n(arst_n), .bus(bus),
  .rdata(rdata), .vdd_above_rt1(vdd_above_rt1), .vdd_above_rt2(vdd_above_rt2), .supply(supply),
  .flash_entry_pin(flash_entry_pin), .reset_out_n(reset_out_n), .regulator_en(regulator_en),
  .gate_disable(gate_disable), .vbat_standby(vbat_standby));
